// ---- design/etmc_core.sv ----
// emulator execution, variant, clock and realtime trace control
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module etmc_core (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [etmc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic variantSwitchDown,
   input wire logic clockSwitchUser,
   input wire logic standaloneMode,
   input wire logic userClk,
   input wire logic [14:0] fetchAddr,
   output logic [7:0] fetchData,
   output logic fetchFromEprom,
   output logic codeRangeFault,
   output logic cpuRun,
   output logic cpuClkTick,
   output logic timerWide,
   output logic serialEnable,
   output logic [10:0] dataMemLow,
   input wire logic instrStart,
   input wire logic instrDone,
   input wire logic breakReq,
   input wire logic [14:0] cpuPc,
   input wire logic [10:0] cpuDataAddr,
   input wire logic [3:0] cpuDataVal,
   input wire logic [3:0] cpuRegA,
   input wire logic [3:0] cpuRegB,
   input wire logic [3:0] cpuRegH,
   input wire logic [3:0] cpuRegL,
   input wire logic [3:0] cpuRegX,
   input wire logic [3:0] cpuRegY,
   input wire logic [7:0] cpuSp,
   input wire logic [3:0] cpuPortA,
   input wire logic [3:0] cpuPortB,
   input wire logic cpuMinus,
   input wire logic cpuCarry,
   input wire logic cpuIntCycle,
   input wire logic cpuSkip
);
   import etmc_pkg::*;

   typedef struct packed {
      etmc_state_t st;
      logic [2:0] varS;
      logic varF;
      logic [2:0] csS;
      logic csF;
      logic [2:0] saS;
      logic saF;
      logic [2:0] ucS;
      logic ucF;
      logic [9:0] divCnt;
      logic [9:0] perCnt;
      logic extFast;
      logic tick;
      logic expand;
      logic pairSel;
      logic oscHigh;
      logic [12:0] tptr;
      logic wrapped;
      logic [12:0] tidx;
      etmc_entry_t snap;
      logic ack;
      logic [31:0] dat;
      logic run;
      logic eprom;
      logic tWide;
      logic serEn;
      logic [10:0] dLow;
      logic fault;
   } etmc_core_t;

   etmc_core_t st_r;
   etmc_core_t st_nxt;
   logic [7:0] code [CODE_DEPTH];
   logic [7:0] fetch_r;
   etmc_entry_t entry;
   logic busReq;
   logic busWr;
   logic codeSel;
   logic codeWr;
   logic [7:0] ofs;
   logic [14:0] codeTop;

   etmc_trace_if tr ();

   etmc_trace_mem u_trace (
      .clk_sys(clk_sys),
      .tr(tr.mem)
   );

   assign busReq = wb_cyc_i && wb_stb_i && !st_r.ack;
   assign busWr = busReq && wb_we_i;
   assign codeSel = wb_adr_i[CODE_SEL_BIT];
   assign ofs = wb_adr_i[7:0];
   // code loads are refused while the processor runs, from the store or in standalone mode from the EPROM
   assign codeWr = busWr && codeSel && wb_sel_i[0] && !st_r.run;

   always_comb begin
      entry.pc = cpuPc;
      entry.dAddr = cpuDataAddr;
      entry.dData = cpuDataVal;
      entry.regA = cpuRegA;
      entry.regB = cpuRegB;
      entry.idxHi = st_r.pairSel ? cpuRegX : cpuRegH;
      entry.idxLo = st_r.pairSel ? cpuRegY : cpuRegL;
      entry.sp = cpuSp;
      entry.ports = {cpuPortB, cpuPortA};
      entry.minus = cpuMinus;
      entry.carry = cpuCarry;
      entry.intCycle = cpuIntCycle;
      entry.skip = cpuSkip;
   end

   always_comb begin
      if (st_r.expand) begin
         codeTop = CODE_TOP_EXP;
      end else if (st_r.varF) begin
         codeTop = CODE_TOP_LARGE;
      end else begin
         codeTop = CODE_TOP_SMALL;
      end
   end

   assign tr.we = st_r.st == ST_RUN && instrStart && !st_r.saF;
   assign tr.waddr = st_r.tptr;
   assign tr.wdata = entry;
   assign tr.raddr = st_r.tidx;

   always_comb begin
      st_nxt = st_r;
      // three stage filters: a level is taken once stages two and three agree
      st_nxt.varS = {st_r.varS[1:0], variantSwitchDown};
      st_nxt.csS = {st_r.csS[1:0], clockSwitchUser};
      st_nxt.saS = {st_r.saS[1:0], standaloneMode};
      st_nxt.ucS = {st_r.ucS[1:0], userClk};
      if (st_r.varS[1] == st_r.varS[2]) begin
         st_nxt.varF = st_r.varS[2];
      end
      if (st_r.csS[1] == st_r.csS[2]) begin
         st_nxt.csF = st_r.csS[2];
      end
      if (st_r.saS[1] == st_r.saS[2]) begin
         st_nxt.saF = st_r.saS[2];
      end
      if (st_r.ucS[1] == st_r.ucS[2]) begin
         st_nxt.ucF = st_r.ucS[2];
      end
      // variant outputs track the filtered switch with no reset in between
      st_nxt.tWide = st_r.varF;
      st_nxt.serEn = st_r.varF;
      st_nxt.dLow = st_r.varF ? DMEM_LO_LARGE : DMEM_LO_SMALL;
      st_nxt.fault = fetchAddr > codeTop;

      st_nxt.tick = 1'b0;
      st_nxt.perCnt = (st_r.perCnt == 10'h3ff) ? st_r.perCnt :
         st_r.perCnt + 10'h001;
      if (st_r.csF) begin
         // user clock: one tick per filtered rising edge
         if (st_r.ucS[2] && !st_r.ucF && st_r.ucS[1]) begin
            st_nxt.tick = 1'b1;
            st_nxt.extFast = st_r.perCnt < PER_MIN;
            st_nxt.perCnt = 10'h000;
         end
      end else begin
         st_nxt.divCnt = st_r.divCnt + 10'h001;
         if (st_r.divCnt >=
            (st_r.oscHigh ? DIV_HIGH : DIV_LOW) - 10'h001) begin
            st_nxt.divCnt = 10'h000;
            st_nxt.tick = 1'b1;
         end
         st_nxt.extFast = 1'b0;
      end

      if (tr.we) begin
         st_nxt.tptr = st_r.tptr + 13'h0001;
         if (st_r.tptr == TPTR_LAST) begin
            st_nxt.wrapped = 1'b1;
         end
      end

      unique case (st_r.st)
         ST_IDLE, ST_HALT: begin
            if (busWr && !codeSel && ofs == OFS_CMD && !st_r.saF) begin
               if (wb_dat_i[CMD_RUN]) begin
                  st_nxt.st = ST_RUN;
               end else if (wb_dat_i[CMD_STEP]) begin
                  st_nxt.st = ST_STEP;
               end
            end
         end
         ST_STEP: begin
            if (instrDone) begin
               st_nxt.st = ST_HALT;
               st_nxt.snap = entry;
            end
         end
         ST_RUN: begin
            if (breakReq || (busWr && !codeSel && ofs == OFS_CMD &&
               wb_dat_i[CMD_STOP])) begin
               st_nxt.st = ST_HALT;
               st_nxt.snap = entry;
            end
         end
      endcase
      if (st_r.saF) begin
         st_nxt.st = ST_IDLE;
      end
      st_nxt.run = st_nxt.st == ST_RUN || st_nxt.st == ST_STEP ||
         st_r.saF;
      st_nxt.eprom = st_r.saF;

      st_nxt.ack = busReq;
      st_nxt.dat = 32'h0000_0000;
      if (busReq && codeSel) begin
         st_nxt.dat = {24'h00_0000, code[wb_adr_i[16:2]]};
      end else if (busReq) begin
         unique case (ofs)
            OFS_CTRL: st_nxt.dat = {29'h0000_0000, st_r.oscHigh,
               st_r.pairSel, st_r.expand};
            OFS_STATUS: st_nxt.dat = {22'h00_0000, st_r.extFast,
               st_r.wrapped, st_r.csF, st_r.saF, st_r.varF, 1'b0,
               st_r.st};
            OFS_TPTR: st_nxt.dat = {19'h0_0000, st_r.tptr};
            OFS_TIDX: st_nxt.dat = {19'h0_0000, st_r.tidx};
            OFS_TDAT0: st_nxt.dat = tr.rdata[31:0];
            OFS_TDAT1: st_nxt.dat = tr.rdata[63:32];
            OFS_TDAT2: st_nxt.dat = {30'h0000_0000, tr.rdata[65:64]};
            OFS_SNAP0: st_nxt.dat = st_r.snap[31:0];
            OFS_SNAP1: st_nxt.dat = st_r.snap[63:32];
            OFS_SNAP2: st_nxt.dat = {30'h0000_0000, st_r.snap[65:64]};
            default: st_nxt.dat = 32'h0000_0000;
         endcase
      end
      if (busWr && !codeSel && wb_sel_i[0]) begin
         if (ofs == OFS_CTRL) begin
            st_nxt.expand = wb_dat_i[CTRL_EXPAND];
            st_nxt.pairSel = wb_dat_i[CTRL_PAIR];
            st_nxt.oscHigh = wb_dat_i[CTRL_OSCHI];
         end
      end
      if (busWr && !codeSel && ofs == OFS_TIDX) begin
         st_nxt.tidx = wb_dat_i[12:0];
      end

      if (rst) begin
         st_nxt = '0;
         st_nxt.st = ST_IDLE;
         st_nxt.dLow = DMEM_LO_SMALL;
      end
   end

   always_ff @(posedge clk_sys) begin
      st_r <= st_nxt;
   end

   // code store: bus loads and fetch share the array
   always_ff @(posedge clk_sys) begin
      if (codeWr) begin
         code[wb_adr_i[16:2]] <= wb_dat_i[7:0];
      end
      fetch_r <= code[fetchAddr];
   end

   assign wb_dat_o = st_r.dat;
   assign wb_ack_o = st_r.ack;
   assign fetchData = fetch_r;
   assign fetchFromEprom = st_r.eprom;
   assign codeRangeFault = st_r.fault;
   assign cpuRun = st_r.run;
   assign cpuClkTick = st_r.tick;
   assign timerWide = st_r.tWide;
   assign serialEnable = st_r.serEn;
   assign dataMemLow = st_r.dLow;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_step_halts: assert property (
      st_r.st == ST_STEP && instrDone && !st_r.saF |=>
      st_r.st == ST_HALT && !cpuRun)
      else $error("step did not halt after one instruction");
   a_break_halts: assert property (
      st_r.st == ST_RUN && breakReq && !st_r.saF |=> st_r.st == ST_HALT)
      else $error("break request did not halt the run");
   a_run_holds: assert property (
      st_r.st == ST_RUN && !breakReq && !busWr && !st_r.saF |=>
      st_r.st == ST_RUN)
      else $error("run ended without a cause");
   a_trace_in_run: assert property (
      tr.we |-> st_r.st == ST_RUN && cpuRun)
      else $error("trace written outside realtime run");
   a_ptr_steps: assert property (
      tr.we |=> st_r.tptr == $past(st_r.tptr) + 13'h0001)
      else $error("trace pointer did not step");
   a_ptr_wraps: assert property (
      tr.we && st_r.tptr == TPTR_LAST |=> st_r.tptr == 13'h0000 &&
      st_r.wrapped)
      else $error("trace pointer did not wrap");
   a_variant_follow: assert property (
      $changed(st_r.varF) |=> timerWide == st_r.varF &&
      serialEnable == st_r.varF)
      else $error("variant outputs lag the switch");
   a_switch_filter: assert property (
      st_r.varS[1] != st_r.varS[2] |=> $stable(st_r.varF))
      else $error("variant taken before filter agreed");
   a_range_small: assert property (
      !st_r.expand && !st_r.varF && fetchAddr > CODE_TOP_SMALL |=>
      codeRangeFault)
      else $error("small variant range not enforced");
   a_standalone: assert property (
      st_r.saF |=> cpuRun && fetchFromEprom && !tr.we)
      else $error("standalone mode not continuous");
   a_ack_pulse: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_osc_tick: assert property (
      !st_r.csF && !st_r.oscHigh && cpuClkTick |=>
      (!cpuClkTick || st_r.csF || st_r.oscHigh) [*8])
      else $error("low oscillator tick too fast");

   c_step: cover property (st_r.st == ST_STEP ##1 st_r.st == ST_HALT);
   c_run_stop: cover property (st_r.st == ST_RUN ##1 st_r.st == ST_HALT);
   c_wrap: cover property (tr.we && st_r.tptr == TPTR_LAST);
   c_variant: cover property ($rose(st_r.varF));
endmodule
`default_nettype wire

// ---- design/etmc_pkg.sv ----
// constants, register map and types of the emulator trace and mode control
`default_nettype none
package etmc_pkg;
   localparam int unsigned SYS_CLK_HZ = 20000000;
   localparam int unsigned OSC_LOW_HZ = 32768;
   localparam int unsigned OSC_HIGH_HZ = 546000;
   localparam int unsigned CLK_MAX_HZ = 700000;
   // periods rounded up so the tick never runs faster than the oscillator
   localparam logic [9:0] DIV_LOW =
      10'((SYS_CLK_HZ + OSC_LOW_HZ - 1) / OSC_LOW_HZ);
   localparam logic [9:0] DIV_HIGH =
      10'((SYS_CLK_HZ + OSC_HIGH_HZ - 1) / OSC_HIGH_HZ);
   localparam logic [9:0] PER_MIN =
      10'(SYS_CLK_HZ / CLK_MAX_HZ);

   localparam int CODE_DEPTH = 32768;
   localparam int TRACE_DEPTH = 8192;
   localparam int TRACE_W = 66;
   localparam logic [14:0] CODE_TOP_SMALL = 15'h07df;
   localparam logic [14:0] CODE_TOP_LARGE = 15'h0fdf;
   localparam logic [14:0] CODE_TOP_EXP = 15'h7fff;
   localparam logic [10:0] DMEM_LO_SMALL = 11'h780;
   localparam logic [10:0] DMEM_LO_LARGE = 11'h700;
   localparam logic [12:0] TPTR_LAST = 13'h1fff;

   // bus map: adr bit 17 selects code memory, one byte per word
   localparam int ADR_W = 18;
   localparam int CODE_SEL_BIT = 17;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_TPTR = 8'h0c;
   localparam logic [7:0] OFS_TIDX = 8'h10;
   localparam logic [7:0] OFS_TDAT0 = 8'h14;
   localparam logic [7:0] OFS_TDAT1 = 8'h18;
   localparam logic [7:0] OFS_TDAT2 = 8'h1c;
   localparam logic [7:0] OFS_SNAP0 = 8'h20;
   localparam logic [7:0] OFS_SNAP1 = 8'h24;
   localparam logic [7:0] OFS_SNAP2 = 8'h28;

   localparam int CTRL_EXPAND = 0;
   localparam int CTRL_PAIR = 1;
   localparam int CTRL_OSCHI = 2;
   localparam int CMD_STEP = 0;
   localparam int CMD_RUN = 1;
   localparam int CMD_STOP = 2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_STEP = 4'b0010,
      ST_RUN = 4'b0100,
      ST_HALT = 4'b1000
   } etmc_state_t;

   typedef struct packed {
      logic skip;
      logic intCycle;
      logic carry;
      logic minus;
      logic [7:0] ports;
      logic [7:0] sp;
      logic [3:0] idxLo;
      logic [3:0] idxHi;
      logic [3:0] regB;
      logic [3:0] regA;
      logic [3:0] dData;
      logic [10:0] dAddr;
      logic [14:0] pc;
   } etmc_entry_t;
endpackage
`default_nettype wire

// ---- design/etmc_trace_if.sv ----
// carrier between the control core and the trace store
`timescale 1ns/1ps
`default_nettype none
interface etmc_trace_if;
   import etmc_pkg::*;
   logic we;
   logic [12:0] waddr;
   etmc_entry_t wdata;
   logic [12:0] raddr;
   etmc_entry_t rdata;
   modport ctl (output we, output waddr, output wdata, output raddr,
      input rdata);
   modport mem (input we, input waddr, input wdata, input raddr,
      output rdata);
endinterface
`default_nettype wire

// ---- design/etmc_trace_mem.sv ----
// trace store, one entry per traced instruction
`timescale 1ns/1ps
`default_nettype none
module etmc_trace_mem (
   input wire logic clk_sys,
   etmc_trace_if.mem tr
);
   import etmc_pkg::*;
   etmc_entry_t store [TRACE_DEPTH];

   always_ff @(posedge clk_sys) begin
      if (tr.we) begin
         store[tr.waddr] <= tr.wdata;
      end
      tr.rdata <= store[tr.raddr];
   end
endmodule
`default_nettype wire

// ---- verif/etmc_user_sys.sv ----
// user side model: processor pacing and user cable clock
`timescale 1ns/1ps
`default_nettype none
module etmc_user_sys (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cpuRun,
   output logic instrStart,
   output logic instrDone,
   output logic userClk,
   output logic [14:0] pc
);
   logic [1:0] ph;
   logic [4:0] div;
   // start is combinational so it never outlives the run enable
   assign instrStart = cpuRun && ph == 2'h0 && !rst;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ph <= 2'h0;
         instrDone <= 1'b0;
         pc <= 15'h0000;
         div <= 5'h00;
         userClk <= 1'b0;
      end else begin
         instrDone <= instrStart;
         ph <= (cpuRun && ph != 2'h2) ? ph + 2'h1 : 2'h0;
         if (instrStart) begin
            pc <= pc + 15'h0001;
         end
         // 40 cycle period, 500 kHz, inside the supported band
         div <= (div == 5'h13) ? 5'h00 : div + 5'h01;
         if (div == 5'h13) begin
            userClk <= ~userClk;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/test_etmc_core.sv ----
// self-checking bench for the emulator trace and mode control core
`timescale 1ns/1ps
`default_nettype none
module test_etmc_core;
   import etmc_pkg::*;
   typedef struct packed {
      logic sw;
      logic expand;
      logic [14:0] addr;
      logic fault;
      logic [10:0] dml;
      logic wide;
   } etmc_row_t;
   localparam etmc_row_t ROWS [6] = '{
      '{1'b0, 1'b0, 15'h07df, 1'b0, 11'h780, 1'b0},
      '{1'b0, 1'b0, 15'h07e0, 1'b1, 11'h780, 1'b0},
      '{1'b1, 1'b0, 15'h0fdf, 1'b0, 11'h700, 1'b1},
      '{1'b1, 1'b0, 15'h0fe0, 1'b1, 11'h700, 1'b1},
      '{1'b1, 1'b1, 15'h7fff, 1'b0, 11'h700, 1'b1},
      '{1'b0, 1'b1, 15'h7fff, 1'b0, 11'h780, 1'b0}};
   localparam int GAPS [3] = '{int'(DIV_LOW), int'(DIV_HIGH), 40};
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [17:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = 4'h1;
   logic [31:0] wb_dat_i = '0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic variantSwitchDown = 1'b0;
   logic clockSwitchUser = 1'b0;
   logic standaloneMode = 1'b0;
   logic breakReq = 1'b0;
   logic [14:0] fetchAddr = '0;
   logic [7:0] fetchData;
   logic fetchFromEprom, codeRangeFault, cpuRun, cpuClkTick, timerWide;
   logic serialEnable, instrStart, instrDone, userClk;
   logic [10:0] dataMemLow, cpuDataAddr;
   logic [14:0] pc, cpuPc;
   logic [3:0] cpuDataVal, cpuRegA, cpuRegB, cpuRegH, cpuRegL, cpuRegX;
   logic [3:0] cpuRegY, cpuPortA, cpuPortB;
   logic [7:0] cpuSp;
   logic cpuMinus, cpuCarry, cpuIntCycle, cpuSkip;
   int nMismatch = 0;
   int checked = 0;
   int cycles = 0;
   int i, g;
   logic [31:0] q;
   logic [65:0] e;

   etmc_core uut (.*);
   etmc_user_sys partner (.*);

   // processor state is a pure function of pc so entries are predictable
   assign cpuPc = pc;
   assign cpuDataAddr = pc[10:0];
   assign cpuDataVal = ~pc[3:0];
   assign cpuRegA = pc[3:0];
   assign cpuRegB = pc[7:4];
   assign cpuRegH = pc[3:0] + 4'h1;
   assign cpuRegL = pc[3:0] + 4'h3;
   assign cpuRegX = pc[3:0] + 4'h2;
   assign cpuRegY = pc[3:0] + 4'h4;
   assign cpuSp = pc[7:0] ^ 8'h5a;
   assign cpuPortA = pc[11:8];
   assign cpuPortB = pc[7:4];
   assign cpuMinus = pc[0];
   assign cpuCarry = pc[1];
   assign cpuIntCycle = pc[2];
   assign cpuSkip = pc[3];

   function automatic etmc_entry_t entryOf(input logic [14:0] p,
      input logic alt);
      etmc_entry_t x;
      x.pc = p;
      x.dAddr = p[10:0];
      x.dData = ~p[3:0];
      x.regA = p[3:0];
      x.regB = p[7:4];
      x.idxHi = p[3:0] + (alt ? 4'h2 : 4'h1);
      x.idxLo = p[3:0] + (alt ? 4'h4 : 4'h3);
      x.sp = p[7:0] ^ 8'h5a;
      x.ports = {p[7:4], p[11:8]};
      {x.skip, x.intCycle, x.carry, x.minus} = p[3:0];
      return x;
   endfunction

   initial begin
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic tally_and_finish;
      if (nMismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         nMismatch++;
         tally_and_finish();
      end
   end

   task automatic check(input string n, input logic [65:0] s,
      input logic [65:0] x);
      checked++;
      if (s !== x) begin
         nMismatch++;
         $display("unexpected %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic wb(input logic we, input logic [17:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // no local limit: only the cycle timeout ends a silent slave
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic readEntry(input logic [7:0] b, output logic [65:0] x);
      logic [31:0] d0, d1, d2;
      wb(1'b0, {10'h000, b}, 32'h0, d0);
      wb(1'b0, {10'h000, b + 8'h04}, 32'h0, d1);
      wb(1'b0, {10'h000, b + 8'h08}, 32'h0, d2);
      x = {d2[1:0], d1, d0};
   endtask

   // measures the second gap so a half-finished period is skipped
   task automatic tickGap(output int t);
      int n;
      n = 0;
      while (cpuClkTick !== 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         n++;
      end
      t = 0;
      do begin
         @(posedge clk_sys);
         t++;
      end while (cpuClkTick !== 1'b1 && t < 2000);
   endtask

   initial begin
      repeat (3) @(posedge clk_sys);
      check("dataMemLow", dataMemLow, 11'h780);
      check("cpuRun", cpuRun, 1'b0);
      rst <= 1'b0;
      wb(1'b0, {10'h000, OFS_STATUS}, 32'h0, q);
      check("status", q[9:0], 10'h001);
      foreach (ROWS[i]) begin
         variantSwitchDown <= ROWS[i].sw;
         wb(1'b1, {10'h000, OFS_CTRL}, {31'h0, ROWS[i].expand}, q);
         fetchAddr <= ROWS[i].addr;
         repeat (8) @(posedge clk_sys);
         check("codeRangeFault", codeRangeFault, ROWS[i].fault);
         check("dataMemLow", dataMemLow, ROWS[i].dml);
         check("timerWide", timerWide, ROWS[i].wide);
         check("serialEnable", serialEnable, ROWS[i].wide);
      end
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      wb(1'b1, {1'b1, 15'h0123, 2'b00}, 32'h3c, q);
      fetchAddr <= 15'h0123;
      repeat (3) @(posedge clk_sys);
      check("fetchData", fetchData, 8'h3c);
      for (i = 0; i < 3; i++) begin
         clockSwitchUser <= (i == 2);
         wb(1'b1, {10'h000, OFS_CTRL}, {29'h0, i == 1, 2'b00}, q);
         tickGap(g);
         tickGap(g);
         check("tick period", g, GAPS[i]);
      end
      clockSwitchUser <= 1'b0;
      wb(1'b1, {10'h000, OFS_CTRL}, 32'h0, q);
      wb(1'b1, {10'h000, OFS_CMD}, 32'h1, q);
      repeat (6) @(posedge clk_sys);
      wb(1'b0, {10'h000, OFS_STATUS}, 32'h0, q);
      check("step state", q[3:0], 4'h8);
      readEntry(OFS_SNAP0, e);
      check("snapshot", e, entryOf(15'h0001, 1'b0));
      wb(1'b0, {10'h000, OFS_TPTR}, 32'h0, q);
      check("tptr", q, 32'h0);
      wb(1'b1, {10'h000, OFS_CTRL}, 32'h2, q);
      wb(1'b1, {10'h000, OFS_CMD}, 32'h2, q);
      repeat (10) @(posedge clk_sys);
      wb(1'b0, {10'h000, OFS_STATUS}, 32'h0, q);
      check("run state", q[3:0], 4'h4);
      for (i = 0; i < 30000 && pc < 15'h2008; i++) @(posedge clk_sys);
      wb(1'b1, {10'h000, OFS_CMD}, 32'h4, q);
      repeat (4) @(posedge clk_sys);
      wb(1'b0, {10'h000, OFS_STATUS}, 32'h0, q);
      check("stopped status", q[9:0], 10'h108);
      wb(1'b0, {10'h000, OFS_TPTR}, 32'h0, q);
      check("tptr", q, {19'h0, 13'(pc - 15'h0001)});
      wb(1'b1, {10'h000, OFS_TIDX}, 32'h0, q);
      readEntry(OFS_TDAT0, e);
      check("trace entry", e, entryOf(15'h2001, 1'b1));
      wb(1'b1, {10'h000, OFS_CMD}, 32'h2, q);
      repeat (10) @(posedge clk_sys);
      breakReq <= 1'b1;
      repeat (3) @(posedge clk_sys);
      breakReq <= 1'b0;
      wb(1'b0, {10'h000, OFS_STATUS}, 32'h0, q);
      check("break state", q[3:0], 4'h8);
      standaloneMode <= 1'b1;
      repeat (8) @(posedge clk_sys);
      check("fetchFromEprom", fetchFromEprom, 1'b1);
      check("cpuRun", cpuRun, 1'b1);
      // code store must refuse writes while the processor runs
      wb(1'b1, {1'b1, 15'h0123, 2'b00}, 32'hc3, q);
      repeat (3) @(posedge clk_sys);
      check("fetchData", fetchData, 8'h3c);
      wb(1'b0, {10'h000, 8'h30}, 32'h0, q);
      check("unmapped", q, 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
